// ===== design/icgo_config.sv
// Gain, range and offset correction registers for the two input channels
//Contract
// - Gain register bits 2:0 choose the channel 1 amplifier gain of 1, 2, 4, 8 or 16.
// - Gain register bits 7:5 choose the channel 2 amplifier gain from the same set.
// - Gain register bits 4:3 choose the channel 1 converter range of 0.5 V, 0.25 V or 0.125 V.
// - Each offset correction value is a six-bit sign-and-magnitude number.
// - The offset step weight follows the selected channel gain.
// - The channel 1 integrator is off after power-up.
// - Bit 7 of the channel 1 offset register switches the channel 1 integrator on or off.
`timescale 1ns/10ps
`default_nettype none
`include "icgo_consts.svh"
module icgo_config (
    input wire logic mclk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [5:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    output logic [2:0] ch1GainShift,
    output logic [2:0] ch2GainShift,
    output icgo_pkg::icgo_range_t ch1Range,
    output logic signed [6:0] ch1OffsetCorr,
    output logic signed [6:0] ch2OffsetCorr,
    output logic integEnable
);
    import icgo_pkg::*;

    icgo_state_t s_q;
    icgo_state_t s_d;

    // True when the bus address selects the given register
    function automatic logic addr_hit(
        input logic [5:0] addr,
        input logic [5:0] target
    );
        addr_hit = (addr == target);
    endfunction : addr_hit

    // A write replaces the whole register; any other cycle keeps it
    function automatic logic [7:0] write_merge(
        input logic [7:0] cur,
        input logic [7:0] wrData,
        input logic hit
    );
        if (hit)
        begin
            write_merge = wrData;
        end
        else
        begin
            write_merge = cur;
        end
    endfunction : write_merge

    // Data of the addressed register; unmapped addresses read as zero
    function automatic logic [7:0] read_mux(
        input logic [5:0] addr,
        input logic [7:0] gain,
        input logic [7:0] ch1,
        input logic [7:0] ch2
    );
        if (addr_hit(addr, `ICGO_ADDR_GAIN))
        begin
            read_mux = gain;
        end
        else if (addr_hit(addr, `ICGO_ADDR_CH1OFS))
        begin
            read_mux = ch1;
        end
        else if (addr_hit(addr, `ICGO_ADDR_CH2OFS))
        begin
            read_mux = ch2;
        end
        else
        begin
            read_mux = 8'h00;
        end
    endfunction : read_mux

    // Channel 1 gain field
    function automatic logic [2:0] gain1_code(
        input logic [7:0] g
    );
        gain1_code = g[`ICGO_GAIN1_MSB:`ICGO_GAIN1_LSB];
    endfunction : gain1_code

    // Channel 2 gain field
    function automatic logic [2:0] gain2_code(
        input logic [7:0] g
    );
        gain2_code = g[`ICGO_GAIN2_MSB:`ICGO_GAIN2_LSB];
    endfunction : gain2_code

    // Channel 1 converter range field
    function automatic logic [1:0] range_code(
        input logic [7:0] g
    );
        range_code = g[`ICGO_RANGE_MSB:`ICGO_RANGE_LSB];
    endfunction : range_code

    // Gain code to shift count; unused codes fall back to unity
    function automatic logic [2:0] gain_shift(
        input logic [2:0] code
    );
        if (code <= 3'h4)
        begin
            gain_shift = code;
        end
        else
        begin
            gain_shift = 3'h0;
        end
    endfunction : gain_shift

    // Range code to full scale; the spare code keeps the widest range
    function automatic icgo_range_t range_sel(
        input logic [1:0] code
    );
        unique case (code)
            2'h1:
            begin
                range_sel = RANGE_QUARTER;
            end
            2'h2:
            begin
                range_sel = RANGE_EIGHTH;
            end
            default:
            begin
                range_sel = RANGE_HALF;
            end
        endcase
    endfunction : range_sel

    // Magnitude field of an offset register
    function automatic logic [4:0] ofs_mag(
        input logic [7:0] r
    );
        ofs_mag = r[`ICGO_OFS_SIGN-1:0];
    endfunction : ofs_mag

    // Sign field of an offset register; set means a negative correction
    function automatic logic ofs_neg(
        input logic [7:0] r
    );
        ofs_neg = r[`ICGO_OFS_SIGN];
    endfunction : ofs_neg

    // Integrator request bit of the channel 1 offset register
    function automatic logic integ_req(
        input logic [7:0] r
    );
        integ_req = r[`ICGO_INTEG_BIT];
    endfunction : integ_req

    // Sign-magnitude to two's complement, so a negative zero reads as zero.
    // The count is gain independent; its weight per step follows the gain shift
    function automatic logic signed [6:0] sm_to_tc(
        input logic [7:0] r
    );
        logic signed [6:0] mag;
        mag = $signed({2'h0, ofs_mag(r)});
        if (ofs_neg(r))
        begin
            sm_to_tc = -mag;
        end
        else
        begin
            sm_to_tc = mag;
        end
    endfunction : sm_to_tc

    always_comb
    begin
        s_d = s_q;
        // Writes; an unmapped address leaves every register alone
        if (regWrite)
        begin
            s_d.gain = write_merge(s_q.gain, regWrData, addr_hit(regAddr, `ICGO_ADDR_GAIN));
            s_d.ch1Ofs = write_merge(s_q.ch1Ofs, regWrData, addr_hit(regAddr, `ICGO_ADDR_CH1OFS));
            s_d.ch2Ofs = write_merge(s_q.ch2Ofs, regWrData, addr_hit(regAddr, `ICGO_ADDR_CH2OFS));
        end
        // A read in the same cycle as a write returns the value from before it
        if (regRead)
        begin
            s_d.rdData = read_mux(regAddr, s_q.gain, s_q.ch1Ofs, s_q.ch2Ofs);
        end
        // Decoded outputs follow the values that this edge stores
        s_d.ch1GainShift = gain_shift(gain1_code(s_d.gain));
        s_d.ch2GainShift = gain_shift(gain2_code(s_d.gain));
        s_d.ch1Range = range_sel(range_code(s_d.gain));
        s_d.ch1OfsVal = sm_to_tc(s_d.ch1Ofs);
        s_d.ch2OfsVal = sm_to_tc(s_d.ch2Ofs);
        s_d.integEnable = integ_req(s_d.ch1Ofs);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.gain <= `ICGO_RST_GAIN;
            s_q.ch1Ofs <= `ICGO_RST_OFS;
            s_q.ch2Ofs <= `ICGO_RST_OFS;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Every output is a plain copy of a register field
    assign regRdData = s_q.rdData;
    assign ch1GainShift = s_q.ch1GainShift;
    assign ch2GainShift = s_q.ch2GainShift;
    assign ch1Range = s_q.ch1Range;
    assign ch1OffsetCorr = s_q.ch1OfsVal;
    assign ch2OffsetCorr = s_q.ch2OfsVal;
    assign integEnable = s_q.integEnable;
endmodule : icgo_config
`default_nettype wire

// ===== design/icgo_consts.svh
// Offsets, field positions and reset values of the input channel gain and offset configuration
`ifndef ICGO_CONSTS_SVH
`define ICGO_CONSTS_SVH
`define ICGO_ADDR_GAIN 6'h0a
`define ICGO_ADDR_CH1OFS 6'h0b
`define ICGO_ADDR_CH2OFS 6'h0c
`define ICGO_GAIN1_LSB 0
`define ICGO_GAIN1_MSB 2
`define ICGO_RANGE_LSB 3
`define ICGO_RANGE_MSB 4
`define ICGO_GAIN2_LSB 5
`define ICGO_GAIN2_MSB 7
`define ICGO_OFS_SIGN 5
`define ICGO_INTEG_BIT 7
`define ICGO_RST_GAIN 8'h00
`define ICGO_RST_OFS 8'h00
`define ICGO_OFS_MAX 5'h1f
`endif

// ===== design/icgo_pkg.sv
// Types of the input channel gain and offset configuration
package icgo_pkg;
    typedef enum logic [1:0] {RANGE_HALF = 2'h0, RANGE_QUARTER = 2'h1, RANGE_EIGHTH = 2'h2} icgo_range_t;
    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] ch1Ofs;
        logic [7:0] ch2Ofs;
        logic [7:0] rdData;
        logic [2:0] ch1GainShift;
        logic [2:0] ch2GainShift;
        icgo_range_t ch1Range;
        logic signed [6:0] ch1OfsVal;
        logic signed [6:0] ch2OfsVal;
        logic integEnable;
    } icgo_state_t;
endpackage : icgo_pkg

// ===== tb/icgo_props.sv
// Checker of the gain, range and offset decode
`timescale 1ns/10ps
`default_nettype none
module icgo_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic [5:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic [2:0] ch1GainShift,
    input wire logic [2:0] ch2GainShift,
    input wire icgo_pkg::icgo_range_t ch1Range,
    input wire logic signed [6:0] ch1OffsetCorr,
    input wire logic signed [6:0] ch2OffsetCorr,
    input wire logic integEnable
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    sequence wrG; regWrite && regAddr == 6'h0a; endsequence
    sequence wr1; regWrite && regAddr == 6'h0b; endsequence
    sequence wr2; regWrite && regAddr == 6'h0c; endsequence
    a_gain1_code: assert property (wrG ##0 regWrData[2:0] < 3'h5 |=> ch1GainShift == $past(regWrData[2:0]))
        else $error("ch1 gain wrong");
    a_gain_unused: assert property (wrG ##0 regWrData[2:0] > 3'h4 |=> ch1GainShift == 3'h0)
        else $error("unused gain code");
    a_gain2_code: assert property (wrG ##0 regWrData[7:5] < 3'h5 |=> ch2GainShift == $past(regWrData[7:5]))
        else $error("ch2 gain wrong");
    a_gain2_unused: assert property (wrG ##0 regWrData[7:5] > 3'h4 |=> ch2GainShift == 3'h0)
        else $error("unused ch2 gain code");
    a_range_map: assert property (wrG |=>
        ch1Range == ($past(regWrData[4:3]) == 2'h3 ? 2'h0 : $past(regWrData[4:3])))
        else $error("range wrong");
    a_ofs1_signmag: assert property (wr1 |=>
        ch1OffsetCorr == ($past(regWrData[5]) ? 7'h0 - $past(regWrData[4:0]) : {2'h0, $past(regWrData[4:0])}))
        else $error("ch1 offset wrong");
    a_ofs2_signmag: assert property (wr2 |=>
        ch2OffsetCorr == ($past(regWrData[5]) ? 7'h0 - $past(regWrData[4:0]) : {2'h0, $past(regWrData[4:0])}))
        else $error("ch2 offset wrong");
    a_integ_set: assert property (wr1 |=> integEnable == $past(regWrData[7])) else $error("integ wrong");
    a_integ_hold: assert property (!regWrite |=> $stable(integEnable)) else $error("integ moved");
    a_integ_off: assert property ($fell(rst) |-> !integEnable) else $error("integ on after reset");
endmodule : icgo_props
bind icgo_config icgo_props u_props (.mclk(mclk), .rst(rst), .regWrite(regWrite), .regAddr(regAddr),
    .regWrData(regWrData), .ch1GainShift(ch1GainShift), .ch2GainShift(ch2GainShift), .ch1Range(ch1Range),
    .ch1OffsetCorr(ch1OffsetCorr), .ch2OffsetCorr(ch2OffsetCorr), .integEnable(integEnable));
`default_nettype wire

// ===== tb/icgo_host.sv
// Host software model driving register writes and reads
`timescale 1ns/10ps
`default_nettype none
module icgo_host (
    input wire logic mclk,
    output logic regWrite = 1'b0,
    output logic regRead = 1'b0,
    output logic [5:0] regAddr = 6'h00,
    output logic [7:0] regWrData = 8'h00
);
    // Callers keep offset magnitudes within 31
    task xfer(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(negedge mclk);
        {regWrite, regRead, regAddr, regWrData} = {w, !w, a, d};
        @(negedge mclk);
        {regWrite, regRead, regWrData} = {2'h0, ~d};
    endtask : xfer
endmodule : icgo_host
`default_nettype wire

// ===== tb/test_input_channel_gain_offset_config.sv
// Testbench of the input channel gain and offset configuration
`timescale 1ns/10ps
`default_nettype none
module test_input_channel_gain_offset_config;
    logic mclk = 1'b0, rst = 1'b1, regWrite, regRead, integEnable;
    logic [5:0] regAddr;
    logic [7:0] regWrData, regRdData, d;
    logic [2:0] ch1GainShift, ch2GainShift, g;
    icgo_pkg::icgo_range_t ch1Range;
    logic signed [6:0] ch1OffsetCorr, ch2OffsetCorr, e;
    int bad_count = 0, n_tests = 0;
    icgo_host host_u (.mclk(mclk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr), .regWrData(regWrData));
    icgo_config dut_u (.mclk(mclk), .rst(rst), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .ch1GainShift(ch1GainShift), .ch2GainShift(ch2GainShift),
        .ch1Range(ch1Range), .ch1OffsetCorr(ch1OffsetCorr), .ch2OffsetCorr(ch2OffsetCorr), .integEnable(integEnable));
    initial forever #2.5 mclk = ~mclk;
    task chk(input string n, input logic [7:0] x, input logic [7:0] s);
        n_tests++;
        if (s !== x) begin $display("ERROR %s expected %h seen %h", n, x, s); bad_count++; end
    endtask : chk
    task test_done;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : test_done
    task t_gain;
        for (int c = 0; c < 8; c++)
        begin
            g = 3'(c);
            host_u.xfer(1'b1, 6'h0a, {g, g[1:0], g});
            chk("gain1", {5'h0, g < 3'h5 ? g : 3'h0}, {5'h0, ch1GainShift});
            chk("gain2", {5'h0, g < 3'h5 ? g : 3'h0}, {5'h0, ch2GainShift});
            chk("range", {6'h0, g[1:0] == 2'h3 ? 2'h0 : g[1:0]}, {6'h0, ch1Range});
        end
        host_u.xfer(1'b0, 6'h0a, 8'h00);
        chk("gain readback", 8'hff, regRdData);
        chk("ofs1 untouched", 8'h00, {1'b0, ch1OffsetCorr});
        chk("ofs2 untouched", 8'h00, {1'b0, ch2OffsetCorr});
        $display("gain test done");
    endtask : t_gain
    task t_ofs;
        logic [7:0] tbl [4] = '{8'h85, 8'h1f, 8'hbf, 8'h20};
        foreach (tbl[i])
        begin
            d = tbl[i];
            e = d[5] ? 7'h0 - d[4:0] : {2'h0, d[4:0]};
            host_u.xfer(1'b1, 6'h0b, d);
            host_u.xfer(1'b1, 6'h0c, d);
            chk("ofs1", {1'b0, e}, {1'b0, ch1OffsetCorr});
            chk("ofs2", {1'b0, e}, {1'b0, ch2OffsetCorr});
            chk("integ", {7'h0, d[7]}, {7'h0, integEnable});
            host_u.xfer(1'b0, 6'h0b, 8'h00);
            chk("readback", d, regRdData);
        end
        host_u.xfer(1'b0, 6'h3f, 8'h00);
        chk("unmapped", 8'h00, regRdData);
        $display("offset test done");
    endtask : t_ofs
    task t_cancel;
        host_u.xfer(1'b1, 6'h0b, 8'h00);
        chk("integ off", 8'h00, {7'h0, integEnable});
        // Grounded inputs show a waveform offset of +7 on channel 1 and -7 on channel 2
        host_u.xfer(1'b1, 6'h0b, 8'h27);
        host_u.xfer(1'b1, 6'h0c, 8'h07);
        host_u.xfer(1'b0, 6'h0b, 8'h00);
        chk("ch1 confirm", 8'h27, regRdData);
        host_u.xfer(1'b0, 6'h0c, 8'h00);
        chk("ch2 confirm", 8'h07, regRdData);
        chk("ch1 cancel", 8'h79, {1'b0, ch1OffsetCorr});
        chk("ch2 cancel", 8'h07, {1'b0, ch2OffsetCorr});
        host_u.xfer(1'b1, 6'h0a, 8'h84);
        chk("gain16 shift", 8'h04, {5'h0, ch1GainShift});
        chk("ofs count kept", 8'h79, {1'b0, ch1OffsetCorr});
        host_u.xfer(1'b1, 6'h0b, 8'ha7);
        chk("integ back on", 8'h01, {7'h0, integEnable});
        chk("ofs with integ", 8'h79, {1'b0, ch1OffsetCorr});
        $display("offset cancel test done");
    endtask : t_cancel
    task t_reset;
        @(negedge mclk);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        chk("integ in reset", 8'h00, {7'h0, integEnable});
        chk("ofs1 in reset", 8'h00, {1'b0, ch1OffsetCorr});
        rst = 1'b0;
        host_u.xfer(1'b0, 6'h0b, 8'h00);
        chk("ch1 after reset", 8'h00, regRdData);
        chk("integ after reset", 8'h00, {7'h0, integEnable});
        $display("reset test done");
    endtask : t_reset
    initial
    begin
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        chk("integ reset", 8'h00, {7'h0, integEnable});
        t_gain();
        t_ofs();
        t_cancel();
        t_reset();
        test_done();
    end
endmodule : test_input_channel_gain_offset_config
`default_nettype wire
